//--- timer_ccp_pkg.sv
// Constants shared by the period timer and its capture/compare channels
`default_nettype none
package timer_ccp_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;
  localparam logic [7:0] ADDR_MODE0 = 8'h14;
  localparam logic [7:0] ADDR_DATA0 = 8'h18;
  localparam logic [7:0] ADDR_MODE1 = 8'h1C;
  localparam logic [7:0] ADDR_DATA1 = 8'h20;
  localparam logic [7:0] ADDR_SPI_SEL = 8'h24;
  // ==========================================================
  // Fields, masks and reset values
  localparam int POST_LSB = 3;
  localparam int RUN_BIT = 2;
  localparam int FLAG_TIMER_BIT = 1;
  localparam int FLAG_CH_LSB = 2;
  localparam logic [7:0] CTRL_MASK = 8'h7F;
  localparam logic [7:0] MODE_MASK = 8'h3F;
  localparam logic [7:0] FLAG_MASK = 8'h0E;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
  localparam logic [3:0] CAP_LAST_4 = 4'h3;
  localparam logic [3:0] CAP_LAST_16 = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Channel mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
endpackage
`default_nettype wire

//--- chan_if.sv
// Link between the timer core and one capture/compare channel
`default_nettype none
interface chan_if;
  logic [3:0] mode;
  logic [15:0] data;
  logic [15:0] timer16;
  logic pin_in;
  logic pin_out;
  logic pin_oe_n;
  logic event_set;
  logic capture;
  logic special;
  modport core (output mode, data, timer16, pin_in,
    input pin_out, pin_oe_n, event_set, capture, special);
  modport chan (input mode, data, timer16, pin_in,
    output pin_out, pin_oe_n, event_set, capture, special);
endinterface
`default_nettype wire

//--- chan_ctrl.sv
// Mode decode, capture edge logic and compare pin actions of one channel
`default_nettype none
module chan_ctrl import timer_ccp_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  chan_if.chan bus
);
  typedef struct packed {
    logic pin;
    logic pin_prev;
    logic eq_prev;
    logic [3:0] cap_cnt;
    logic [3:0] mode_prev;
  } chan_state_t;
  chan_state_t s_reg, s_next;
  logic [3:0] m;
  logic is_cap, is_cmp, eq, hit, rise, fall, cap;

  always_comb begin
    m = bus.mode;
    is_cap = (m[3:2] == 2'b01);
    is_cmp = (m == MODE_TOGGLE) || (m[3:2] == 2'b10);
    eq = (bus.timer16 == bus.data);
    // Match acts once per equality, not every cycle it holds
    hit = is_cmp && eq && !s_reg.eq_prev;
    rise = bus.pin_in && !s_reg.pin_prev;
    fall = !bus.pin_in && s_reg.pin_prev;
    s_next = s_reg;
    s_next.pin_prev = bus.pin_in;
    s_next.eq_prev = eq;
    s_next.mode_prev = m;
    cap = 1'b0;
    unique case (m)
      MODE_CAP_FALL: cap = fall;
      MODE_CAP_RISE: cap = rise;
      MODE_CAP_4: cap = rise && (s_reg.cap_cnt == CAP_LAST_4);
      MODE_CAP_16: cap = rise && (s_reg.cap_cnt == CAP_LAST_16);
      default: cap = 1'b0;
    endcase
    if (!is_cap)
      s_next.cap_cnt = 4'h0;
    else if (cap)
      s_next.cap_cnt = 4'h0;
    else if (rise)
      s_next.cap_cnt = s_reg.cap_cnt + 4'h1;
    if (m == MODE_OFF) begin
      s_next.pin = 1'b0;
      s_next.cap_cnt = 4'h0;
    end else if (m != s_reg.mode_prev) begin
      if (m == MODE_SET_HIGH)
        s_next.pin = 1'b0;
      else if (m == MODE_SET_LOW)
        s_next.pin = 1'b1;
    end else if (hit) begin
      if (m == MODE_TOGGLE)
        s_next.pin = !s_reg.pin;
      else if (m == MODE_SET_HIGH)
        s_next.pin = 1'b1;
      else if (m == MODE_SET_LOW)
        s_next.pin = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Soft mode leaves the pin to its port latch
  assign bus.pin_out = s_reg.pin;
  assign bus.pin_oe_n = !((m == MODE_TOGGLE) || (m == MODE_SET_HIGH) || (m == MODE_SET_LOW));
  assign bus.event_set = hit || cap;
  assign bus.capture = cap;
  assign bus.special = hit && (m == MODE_SPECIAL);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  pin_toggle_a: assert property (hit && m == MODE_TOGGLE && $stable(m) |=>
    bus.pin_out != $past(bus.pin_out)) else $error("toggle missed");
  pin_high_a: assert property (hit && m == MODE_SET_HIGH && $stable(m) |=>
    bus.pin_out) else $error("pin not forced high");
  pin_low_a: assert property (hit && m == MODE_SET_LOW && $stable(m) |=>
    !bus.pin_out) else $error("pin not forced low");
  off_reset_a: assert property (m == MODE_OFF |=> !bus.pin_out && s_reg.cap_cnt == 4'h0)
    else $error("disabled channel not reset");
  cap16_cover: cover property (m == MODE_CAP_16 && cap);
endmodule // chan_ctrl
`default_nettype wire

//--- timer_ccp_top.sv
// Period timer with pre/postscaler, match flag and two channel controllers
`default_nettype none
module timer_ccp_top import timer_ccp_pkg::*; #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Free-running 16-bit timer compared and captured by the channels
  input wire logic [15:0] cmp_timer,
  // Channel pins
  input wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0] channel_pin_out,
  output logic [NUM_CH-1:0] channel_pin_oe_n,
  // Events and time bases
  output logic pwm_time_base,
  output logic [NUM_CH-1:0][9:0] pwm_duty,
  output logic spi_shift_tick,
  output logic [NUM_CH-1:0] special_event,
  output logic irq_req
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] limit;
    logic [3:0] pre;
    logic [3:0] post;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [NUM_CH-1:0][7:0] mode;
    logic [NUM_CH-1:0][15:0] data;
    logic spi_sel;
    logic awg;
    logic wg;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_t;
  top_state_t s_reg, s_next;

  logic [NUM_CH-1:0] ch_event, ch_capture;
  logic run, tick, match, wr_fire, hit_ok;
  logic [3:0] pre_last, post_sel;

  // ==========================================================
  // Channel instances
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    chan_if cif();
    assign cif.mode = s_reg.mode[i][3:0];
    assign cif.data = s_reg.data[i];
    assign cif.timer16 = cmp_timer;
    assign cif.pin_in = channel_pin_in[i];
    assign channel_pin_out[i] = cif.pin_out;
    assign channel_pin_oe_n[i] = cif.pin_oe_n;
    assign ch_event[i] = cif.event_set;
    assign ch_capture[i] = cif.capture;
    assign special_event[i] = cif.special;
    // Duty only means something in PWM modes
    assign pwm_duty[i] = {s_reg.data[i][7:0], s_reg.mode[i][5:4]};
    chan_ctrl u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(cif.chan)
    );
  end

  // ==========================================================
  // Register read mux
  function automatic logic [32:0] read_reg(input top_state_t st, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (a)
      ADDR_CTRL: r = {1'b1, 24'h0, st.ctrl};
      ADDR_COUNT: r = {1'b1, 24'h0, st.count};
      ADDR_LIMIT: r = {1'b1, 24'h0, st.limit};
      ADDR_FLAGS: r = {1'b1, 24'h0, st.flags};
      ADDR_ENABLES: r = {1'b1, 24'h0, st.enables};
      ADDR_MODE0: r = {1'b1, 24'h0, st.mode[0]};
      ADDR_DATA0: r = {1'b1, 16'h0, st.data[0]};
      ADDR_MODE1: r = {1'b1, 24'h0, st.mode[1]};
      ADDR_DATA1: r = {1'b1, 16'h0, st.data[1]};
      ADDR_SPI_SEL: r = {1'b1, 31'h0, st.spi_sel};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [32:0] rd;
    rd = read_reg(s_reg, araddr);
    s_next = s_reg;
    run = s_reg.ctrl[RUN_BIT];
    post_sel = s_reg.ctrl[POST_LSB +: 4];
    unique case (s_reg.ctrl[1:0])
      2'b00: pre_last = 4'h0;
      2'b01: pre_last = PRE_LAST_DIV4;
      default: pre_last = PRE_LAST_DIV16;
    endcase
    tick = run && (s_reg.pre == pre_last);
    match = tick && (s_reg.count == s_reg.limit);
    wr_fire = s_reg.awg && s_reg.wg && !s_reg.bvalid;
    hit_ok = 1'b1;
    if (run)
      s_next.pre = tick ? 4'h0 : s_reg.pre + 4'h1;
    if (tick)
      s_next.count = match ? 8'h00 : s_reg.count + 8'h01;
    if (match)
      s_next.post = (s_reg.post == post_sel) ? 4'h0 : s_reg.post + 4'h1;
    // Write channels are taken in either order
    if (awvalid && awready) begin
      s_next.awg = 1'b1;
      s_next.awa = awaddr;
    end
    if (wvalid && wready) begin
      s_next.wg = 1'b1;
      s_next.wd = wdata;
      s_next.ws = wstrb;
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (wr_fire) begin
      s_next.awg = 1'b0;
      s_next.wg = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      // Only lane 0 carries the byte registers
      unique case (s_reg.awa)
        ADDR_CTRL: if (s_reg.ws[0]) begin
          s_next.ctrl = s_reg.wd[7:0] & CTRL_MASK;
          s_next.pre = 4'h0;
          s_next.post = 4'h0;
        end
        ADDR_COUNT: if (s_reg.ws[0]) begin
          s_next.count = s_reg.wd[7:0];
          s_next.pre = 4'h0;
          s_next.post = 4'h0;
          hit_ok = 1'b0;
        end
        ADDR_LIMIT: if (s_reg.ws[0]) s_next.limit = s_reg.wd[7:0];
        ADDR_FLAGS: if (s_reg.ws[0]) s_next.flags = s_reg.wd[7:0] & FLAG_MASK;
        ADDR_ENABLES: if (s_reg.ws[0]) s_next.enables = s_reg.wd[7:0] & FLAG_MASK;
        ADDR_MODE0: if (s_reg.ws[0]) s_next.mode[0] = s_reg.wd[7:0] & MODE_MASK;
        ADDR_MODE1: if (s_reg.ws[0]) s_next.mode[1] = s_reg.wd[7:0] & MODE_MASK;
        ADDR_DATA0: begin
          if (s_reg.ws[0]) s_next.data[0][7:0] = s_reg.wd[7:0];
          if (s_reg.ws[1]) s_next.data[0][15:8] = s_reg.wd[15:8];
        end
        ADDR_DATA1: begin
          if (s_reg.ws[0]) s_next.data[1][7:0] = s_reg.wd[7:0];
          if (s_reg.ws[1]) s_next.data[1][15:8] = s_reg.wd[15:8];
        end
        ADDR_SPI_SEL: if (s_reg.ws[0]) s_next.spi_sel = s_reg.wd[0];
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    // Hardware sets win over a software clear in the same cycle
    if (match && (s_reg.post == post_sel) && hit_ok)
      s_next.flags[FLAG_TIMER_BIT] = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_event[i])
        s_next.flags[FLAG_CH_LSB + i] = 1'b1;
      // Capture overrides a software data write in the same cycle
      if (ch_capture[i])
        s_next.data[i] = cmp_timer;
    end
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.limit <= LIMIT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign awready = !s_reg.awg && !s_reg.bvalid;
  assign wready = !s_reg.wg && !s_reg.bvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign pwm_time_base = match;
  assign spi_shift_tick = match && s_reg.spi_sel;
  assign irq_req = s_reg.flags[FLAG_TIMER_BIT] && s_reg.enables[FLAG_TIMER_BIT];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  timer_stop_a: assert property (!run && !wr_fire |=> $stable(s_reg.count))
    else $error("stopped timer moved");
  match_wrap_a: assert property (match && !wr_fire |=> s_reg.count == 8'h00)
    else $error("counter not zero after match");
  flag_post_a: assert property (match && s_reg.post == post_sel && hit_ok |=>
    s_reg.flags[FLAG_TIMER_BIT]) else $error("flag not raised at postscale");
  // Software may set the flag directly, so only hardware rises are checked
  no_early_a: assert property ($rose(s_reg.flags[FLAG_TIMER_BIT]) &&
    !$past(wr_fire && s_reg.awa == ADDR_FLAGS)
    |-> $past(match) && $past(s_reg.post) == $past(post_sel)) else $error("early flag");
  flag_latch_a: assert property (s_reg.flags[FLAG_TIMER_BIT] &&
    !(wr_fire && s_reg.awa == ADDR_FLAGS) |=> s_reg.flags[FLAG_TIMER_BIT])
    else $error("flag not held");
  ctrl_clear_a: assert property (wr_fire && s_reg.awa == ADDR_CTRL && s_reg.ws[0] |=>
    s_reg.pre == 4'h0 && s_reg.post == 4'h0) else $error("scalers not cleared");
  reserved_a: assert property (!s_reg.ctrl[7] && s_reg.mode[0][7:6] == 2'b00 &&
    s_reg.mode[1][7:6] == 2'b00) else $error("reserved bit set");
  base_a: assert property (pwm_time_base |-> run && s_reg.count == s_reg.limit)
    else $error("time base wrong");
  spi_a: assert property (spi_shift_tick |-> pwm_time_base && s_reg.spi_sel)
    else $error("shift tick wrong");
  // A write in the window may clear the prescaler or stop the timer
  div4_a: assert property (tick && s_reg.ctrl[1:0] == 2'b01 && !wr_fire
    ##1 !wr_fire [*3] |=> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
    else $error("divide by four wrong");
  match_cover: cover property (match);
  flag_cover: cover property ($rose(s_reg.flags[FLAG_TIMER_BIT]) && post_sel == 4'hF);
  write_cover: cover property (bvalid && bready ##1 rvalid && rready);
endmodule // timer_ccp_top
`default_nettype wire

//--- chan_partner.sv
// Behavioural far side: free-running compare timer and channel pin drivers
`default_nettype none
module chan_partner (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control of the outside pin sources
  input wire logic [1:0] ext_level,
  // Design side
  input wire logic [1:0] channel_pin_out,
  input wire logic [1:0] channel_pin_oe_n,
  output logic [1:0] channel_pin_in,
  output logic [15:0] cmp_timer
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Timer
  // Nonzero start value, so a stuck-at-zero capture is not mistaken for a hit
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_timer <= 16'h0100;
    end else begin
      cmp_timer <= cmp_timer + 16'h0001;
    end
  end
  // ==========================================================
  // Pin wire
  // Design wins while its enable is low, else the outside source
  assign channel_pin_in = (~channel_pin_oe_n & channel_pin_out) | (channel_pin_oe_n & ext_level);
endmodule // chan_partner
`default_nettype wire

//--- period_timer_ccp_mode_control_tb_top.sv
// Self-checking bench for the period timer and channel mode control
`default_nettype none
module period_timer_ccp_mode_control_tb_top import timer_ccp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] ext_level = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, pwm_time_base, spi_shift_tick, irq_req;
  logic [1:0] bresp, rresp, channel_pin_in, channel_pin_out, channel_pin_oe_n, special_event;
  logic [31:0] rdata;
  logic [15:0] cmp_timer, cap_t;
  logic [1:0][9:0] pwm_duty;
  logic [1:0] resp;
  logic spi_sel = 1'b0;
  logic [3:0] cmp_codes [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
  int n_fail = 0, n_compared = 0, pulse_cnt = 0, since = 0, period = 0, spi_bad = 0, sp_cnt = 0;

  timer_ccp_top #(.NUM_CH(2)) uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .cmp_timer, .channel_pin_in, .channel_pin_out, .channel_pin_oe_n,
    .pwm_time_base, .pwm_duty, .spi_shift_tick, .special_event, .irq_req);
  chan_partner far (.aclk, .aresetn, .ext_level, .channel_pin_out, .channel_pin_oe_n,
    .channel_pin_in, .cmp_timer);

  initial begin
    forever #5 aclk = ~aclk;
  end
  // ==========================================================
  // Monitors
  // Counters move by non-blocking update so tasks read settled values
  always @(posedge aclk) begin
    if (pwm_time_base === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
      period <= since;
      since <= 1;
    end else begin
      since <= since + 1;
    end
    if (spi_shift_tick !== (pwm_time_base & spi_sel)) spi_bad <= spi_bad + 1;
    if (special_event !== 2'h0) sp_cnt <= sp_cnt + 1;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic pin_to(input logic l);
    @(posedge aclk);
    cap_t = cmp_timer;
    ext_level[0] <= l;
    repeat (3) @(posedge aclk);
  endtask
  task automatic finish_test();
    $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Watchdog, well beyond the expected run of some 5000 cycles
  initial begin
    #600000;
    n_fail++;
    finish_test();
  end
  // ==========================================================
  // Tests
  initial begin
    logic [31:0] v, v2;
    logic [15:0] d;
    logic [7:0] madr, b;
    logic [3:0] m;
    logic [1:0] dc;
    logic p0;
    int lim, post, base, need, ch;
    void'($urandom(32'hAE2B5558));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, v);
    chk("ctrl reset", 32'h0, v);
    rd(ADDR_MODE0, v);
    chk("mode0 reset", 32'h0, v);
    rd(ADDR_LIMIT, v);
    chk("limit reset", 32'hFF, v);
    wr(ADDR_CTRL, 32'hFF);
    rd(ADDR_CTRL, v);
    chk("ctrl unused bit", 32'h7F, v);
    wr(ADDR_MODE1, 32'hFF);
    rd(ADDR_MODE1, v);
    chk("mode unused bits", 32'h3F, v);
    wr(ADDR_MODE1, 32'h0);
    wr(8'h28, 32'h1);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
    rd(8'h28, v);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
    $display("test registers done");
    for (int t = 0; t < 4; t++) begin
      lim = $urandom_range(6, 1);
      // Last pass takes the longest postscale
      post = (t == 3) ? 15 : $urandom_range(3, 0);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_FLAGS, 32'h0);
      wr(ADDR_ENABLES, 32'h2);
      wr(ADDR_LIMIT, 32'(lim));
      wr(ADDR_SPI_SEL, 32'(t % 2));
      spi_sel = t[0];
      base = pulse_cnt;
      wr(ADDR_CTRL, 32'((post << POST_LSB) | (1 << RUN_BIT) | t));
      do @(posedge aclk); while (irq_req !== 1'b1);
      chk("matches before flag", 32'(post + 1), 32'(pulse_cnt - base));
      base = pulse_cnt + 2;
      do @(posedge aclk); while (pulse_cnt < base);
      need = (lim + 1) * (t == 0 ? 1 : t == 1 ? 4 : 16);
      chk("match period", 32'(need), 32'(period));
      wr(ADDR_ENABLES, 32'h0);
      chk("irq masked", 32'h0, 32'(irq_req));
      rd(ADDR_FLAGS, v);
      chk("timer flag", 32'h1, 32'(v[FLAG_TIMER_BIT]));
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_COUNT, v);
      repeat (40) @(posedge aclk);
      rd(ADDR_COUNT, v2);
      chk("count stopped", v, v2);
    end
    chk("spi tick", 32'h0, 32'(spi_bad));
    wr(ADDR_LIMIT, 32'hFF);
    wr(ADDR_COUNT, 32'h5);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_COUNT, v);
    chk("count kept", 32'h5, v);
    $display("test timer done");
    for (int i = 0; i < 5; i++) begin
      ch = i % 2;
      m = cmp_codes[i];
      madr = (ch == 1) ? ADDR_MODE1 : ADDR_MODE0;
      wr(madr, 32'h0);
      wr(ADDR_FLAGS, 32'h0);
      d = cmp_timer + 16'h0050;
      wr(madr + 8'h04, 32'(d));
      base = sp_cnt;
      wr(madr, 32'(m));
      repeat (2) @(posedge aclk);
      p0 = channel_pin_out[ch];
      chk("pin enable", 32'(m == 4'hA || m == 4'hB), 32'(channel_pin_oe_n[ch]));
      if (m == 4'h8 || m == 4'h9) chk("pin init", 32'(m == 4'h9), 32'(p0));
      do @(posedge aclk); while (cmp_timer !== d);
      repeat (3) @(posedge aclk);
      v2 = 32'(m == 4'h8 || (m == 4'h2 && !p0));
      if (m < 4'hA) chk("pin after match", v2, 32'(channel_pin_out[ch]));
      chk("special pulses", 32'(m == 4'hB), 32'(sp_cnt - base));
      rd(ADDR_FLAGS, v);
      chk("channel flag", 32'h1, 32'(v[FLAG_CH_LSB + ch]));
    end
    $display("test compare done");
    for (int k = 4; k < 8; k++) begin
      need = (k == 6) ? 4 : (k == 7) ? 16 : 1;
      pin_to(1'b0);
      wr(ADDR_MODE0, 32'h0);
      wr(ADDR_FLAGS, 32'h0);
      wr(ADDR_MODE0, 32'(k));
      for (int i = 0; i < need; i++) begin
        if (i == need - 1) begin
          rd(ADDR_FLAGS, v);
          chk("flag before last edge", 32'h0, 32'(v[FLAG_CH_LSB]));
        end
        pin_to(1'b1);
        if (i < need - 1) pin_to(1'b0);
      end
      rd(ADDR_FLAGS, v);
      chk("flag after rise", 32'(k != 4), 32'(v[FLAG_CH_LSB]));
      if (k != 4) begin
        rd(ADDR_DATA0, v);
        chk("capture time", 32'h1, 32'((v[15:0] - cap_t) inside {[16'h1:16'h4]}));
      end
      pin_to(1'b0);
      rd(ADDR_FLAGS, v);
      chk("flag after fall", 32'h1, 32'(v[FLAG_CH_LSB]));
    end
    $display("test capture done");
    for (int k = 12; k < 16; k++) begin
      b = 8'($urandom);
      dc = 2'($urandom);
      wr(ADDR_DATA0, 32'(b));
      wr(ADDR_MODE0, 32'({dc, 4'(k)}));
      chk("pwm duty", 32'({b, dc}), 32'(pwm_duty[0]));
    end
    wr(ADDR_MODE1, 32'h9);
    wr(ADDR_MODE1, 32'h0);
    repeat (2) @(posedge aclk);
    chk("off pin level", 32'h0, 32'(channel_pin_out[1]));
    chk("off pin enable", 32'h1, 32'(channel_pin_oe_n[1]));
    $display("test pwm and off done");
    finish_test();
  end
endmodule // period_timer_ccp_mode_control_tb_top
`default_nettype wire
